// file: hdl/cyt_link_regs.sv
// Link cycle timer, link status and link interrupt flag registers behind AXI4-Lite.
`timescale 1ns/1ps
module cyt_link_regs
  import cyt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Link-side status pins
  input wire logic external_cycle_input_i,
  input wire logic transmitter_idle_flag_i,
  input wire logic root_node_i,
  input wire logic selfid_done_i,
  input wire logic next_retry_phase_i,
  input wire logic [ACK_W-1:0] last_async_tx_ack_i,
  input wire logic reset_start_wr_i,
  input wire logic bus_idle_i,
  // Outputs
  output logic cycle_start_o,
  output logic irq_o
);
  cyt_sync_if #(.W(SYN_W)) sif ();
  cyt_sync #(.W(SYN_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .sif(sif)
  );
  assign sif.raw = {last_async_tx_ack_i, bus_idle_i, reset_start_wr_i, next_retry_phase_i,
                    selfid_done_i, root_node_i, transmitter_idle_flag_i, external_cycle_input_i};

  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] ctrl_reg, irq_stat_reg, irq_stat_next, irq_en_reg, cyc_tm_reg, cyc_tm_next;
  logic [TMR_W-1:0] tmr_reload_reg, tmr_cnt_reg;
  logic tmr_rpt_reg, tmr_active_reg;
  logic [3:0] div_reg;
  logic [GAP_W-1:0] gap_cnt_reg;
  logic gap_done_reg, root_reg, ext_d_reg, selfid_d_reg, rstart_d_reg, cstart_reg;
  logic cyc_inc;

  // Register bus decode.
  wire do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [31:0] bmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] wval = w_data_reg & bmask;
  wire wr_ctrl = do_wr && (aw_addr_reg == CTRL_OFS);
  wire wr_stat = do_wr && (aw_addr_reg == IRQ_STAT_OFS);
  wire wr_en = do_wr && (aw_addr_reg == IRQ_EN_OFS);
  wire wr_cyc = do_wr && (aw_addr_reg == CYC_TM_OFS);
  wire wr_tmr = do_wr && (aw_addr_reg == TIMER_OFS);
  wire wr_hit = wr_ctrl || wr_stat || wr_en || wr_cyc || wr_tmr;
  wire ar_hs = s_axi_arvalid && !rvalid_reg;
  wire rd_hit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == IRQ_STAT_OFS) ||
                (s_axi_araddr == IRQ_EN_OFS) || (s_axi_araddr == CYC_TM_OFS) ||
                (s_axi_araddr == TIMER_OFS);

  // Clean link-side levels and their edges.
  wire ext_c = sif.clean[SYN_EXT];
  wire root_c = sif.clean[SYN_ROOT];
  wire selfid_c = sif.clean[SYN_SELFID];
  wire rstart_c = sif.clean[SYN_RSTART];
  wire idle_c = sif.clean[SYN_IDLE];
  wire ext_rise = ext_c && !ext_d_reg;
  wire selfid_rise = selfid_c && !selfid_d_reg;
  wire tick = (div_reg == TICK_DIV - 4'h1);

  // Control bits, live status bits and the latched root bit.
  wire src_ext = ctrl_reg[CTL_SOURCE_BIT];
  wire tmr_run = ctrl_reg[CTL_RUN_BIT];
  wire master_en = ctrl_reg[CTL_MASTER_BIT];
  wire [31:0] ctrl_rd = ctrl_reg |
                        ({28'h0, sif.clean[SYN_ACK_LSB +: ACK_W]} << CTL_ACK_LSB) |
                        ({31'h0, sif.clean[SYN_TXIDLE]} << CTL_TXIDLE_BIT) |
                        ({31'h0, root_reg} << CTL_ROOT_BIT) |
                        ({31'h0, sif.clean[SYN_RETRY]} << CTL_RETRY_BIT);
  wire [31:0] tmr_rd = ({31'h0, tmr_rpt_reg} << TMR_RPT_BIT) | {16'h0, tmr_cnt_reg};
  wire [31:0] rd_mux = (s_axi_araddr == CTRL_OFS) ? ctrl_rd :
                       (s_axi_araddr == IRQ_STAT_OFS) ? irq_stat_reg :
                       (s_axi_araddr == IRQ_EN_OFS) ? irq_en_reg :
                       (s_axi_araddr == CYC_TM_OFS) ? cyc_tm_reg :
                       (s_axi_araddr == TIMER_OFS) ? tmr_rd : 32'h0;

  // Events that set status flags.
  wire tmr_zero = tmr_active_reg && tick && (tmr_cnt_reg == 16'h1);
  wire gap_hit = idle_c && !gap_done_reg && (gap_cnt_reg == GAP_W'(FAIR_GAP_CYC - 1));
  wire [31:0] ev = ({31'h0, tmr_zero} << IRQ_TIMER_BIT) |
                   ({31'h0, rstart_c && !rstart_d_reg} << IRQ_COMMAND_RESET_FLAG_BIT) |
                   ({31'h0, gap_hit} << IRQ_GAP_BIT);
  wire [31:0] w1c = wr_stat ? wval : 32'h0;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign cycle_start_o = cstart_reg;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  always_comb begin
    // Clearing a zero bit leaves it zero, and an event in the same cycle stays set.
    irq_stat_next = (irq_stat_reg & ~w1c) | ev;
  end

  always_comb begin
    cyc_tm_next = cyc_tm_reg;
    cyc_inc = 1'b0;
    if (wr_cyc) begin
      // Writes always load; a stopped timer with no external-source edge thus reads back what was written.
      cyc_tm_next = (cyc_tm_reg & ~bmask) | wval;
    end else begin
      if (tmr_run && tick) begin
        if (cyc_tm_reg[CYC_OFS_W-1:0] == CYC_OFS_MAX) begin
          cyc_tm_next[CYC_OFS_W-1:0] = 12'h0;
          cyc_inc = !src_ext;
        end else begin
          cyc_tm_next[CYC_OFS_W-1:0] = cyc_tm_reg[CYC_OFS_W-1:0] + 12'h1;
        end
      end
      if (src_ext && ext_rise) begin
        cyc_tm_next[CYC_OFS_W-1:0] = 12'h0;
        cyc_inc = 1'b1;
      end
      if (cyc_inc) begin
        cyc_tm_next[CYC_CNT_LSB +: CYC_CNT_W] = cyc_tm_reg[CYC_CNT_LSB +: CYC_CNT_W] + 13'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
      end
      if (do_wr) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_reg <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl_reg <= CTRL_RESET;
      irq_stat_reg <= IRQ_RESET;
      irq_en_reg <= IRQ_RESET;
      cyc_tm_reg <= CYC_RESET;
      div_reg <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~(bmask & CTRL_WMASK)) | (wval & CTRL_WMASK);
      end
      if (wr_en) begin
        irq_en_reg <= (irq_en_reg & ~bmask) | wval;
      end
      irq_stat_reg <= irq_stat_next;
      cyc_tm_reg <= cyc_tm_next;
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
    end
  end

  // Edge history and the root bit latched when self-identification ends.
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ext_d_reg <= 1'b0;
      selfid_d_reg <= 1'b0;
      rstart_d_reg <= 1'b0;
      root_reg <= 1'b0;
      cstart_reg <= 1'b0;
    end else begin
      ext_d_reg <= ext_c;
      selfid_d_reg <= selfid_c;
      rstart_d_reg <= rstart_c;
      if (selfid_rise) begin
        root_reg <= root_c;
      end
      cstart_reg <= cyc_inc && root_reg && master_en;
    end
  end

  // Countdown timer; a non-zero write loads the period and restarts it, a zero write stops it.
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tmr_reload_reg <= 16'h0;
      tmr_cnt_reg <= 16'h0;
      tmr_rpt_reg <= 1'b0;
      tmr_active_reg <= 1'b0;
    end else if (wr_tmr) begin
      tmr_reload_reg <= w_data_reg[TMR_W-1:0];
      tmr_cnt_reg <= w_data_reg[TMR_W-1:0];
      tmr_rpt_reg <= w_data_reg[TMR_RPT_BIT];
      tmr_active_reg <= (w_data_reg[TMR_W-1:0] != 16'h0);
    end else if (tmr_zero) begin
      tmr_cnt_reg <= tmr_rpt_reg ? tmr_reload_reg : 16'h0;
      tmr_active_reg <= tmr_rpt_reg;
    end else if (tmr_active_reg && tick) begin
      tmr_cnt_reg <= tmr_cnt_reg - 16'h1;
    end
  end

  // Gap detector fires once per idle stretch so a long idle bus gives one event.
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !idle_c) begin
      gap_cnt_reg <= '0;
      gap_done_reg <= 1'b0;
    end else if (gap_hit) begin
      gap_done_reg <= 1'b1;
    end else if (!gap_done_reg) begin
      gap_cnt_reg <= gap_cnt_reg + GAP_W'(1);
    end
  end

  AST_EXT_EDGE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    src_ext && ext_rise && !wr_cyc |=> cyc_tm_reg[CYC_OFS_W-1:0] == 12'h0 &&
    cyc_tm_reg[CYC_CNT_LSB +: CYC_CNT_W] == $past(cyc_tm_reg[CYC_CNT_LSB +: CYC_CNT_W]) + 13'h1)
    else $error("External cycle edge did not advance the count.");
  AST_WRAP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !src_ext && tmr_run && tick && !wr_cyc && cyc_tm_reg[CYC_OFS_W-1:0] == CYC_OFS_MAX |=>
    cyc_tm_reg[CYC_CNT_LSB +: CYC_CNT_W] == $past(cyc_tm_reg[CYC_CNT_LSB +: CYC_CNT_W]) + 13'h1)
    else $error("Offset wrap did not advance the count.");
  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !tmr_run && !wr_cyc && !(src_ext && ext_rise) |=> $stable(cyc_tm_reg))
    else $error("Stopped cycle timer changed.");
  AST_SCRATCH: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_cyc && w_strb_reg == 4'hf ##1 !tmr_run && !(src_ext && ext_rise) [*2] |->
    cyc_tm_reg == $past(w_data_reg, 2))
    else $error("Scratch value not kept.");
  AST_ROOT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    selfid_rise |=> root_reg == $past(root_c))
    else $error("Root bit not refreshed after self-ID.");
  AST_W1C: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_stat |=> (irq_stat_reg & $past(w1c & ~ev)) == 32'h0)
    else $error("Written-one status bit not cleared.");
  AST_SET_WINS: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ev & w1c) != 32'h0 |=> (irq_stat_reg & $past(ev)) == $past(ev))
    else $error("Clear beat a simultaneous event.");
  AST_TIMER: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    tmr_zero && !wr_tmr |=> irq_stat_reg[IRQ_TIMER_BIT] && tmr_active_reg == $past(tmr_rpt_reg))
    else $error("Timer zero not flagged.");
  AST_GAP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    gap_hit |=> irq_stat_reg[IRQ_GAP_BIT] ##1 !gap_hit)
    else $error("Idle gap not flagged once.");
  AST_CSTART: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cyc_inc && root_reg && master_en |=> cycle_start_o ##1 !cycle_start_o || cyc_inc)
    else $error("Cycle start not sent on increment.");
  AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (ev & irq_en_reg) != 32'h0 |=> irq_o)
    else $error("Enabled event did not raise the interrupt.");

  // These guard flag and counter paths that the bus-level tests reach only now and then.
  AST_COMMAND_RESET_FLAG: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rstart_c && !rstart_d_reg |=> irq_stat_reg[IRQ_COMMAND_RESET_FLAG_BIT])
    else $error("Reset-start request not flagged.");
  AST_NO_WR_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_stat && ev == 32'h0 |=> (irq_stat_reg & ~$past(irq_stat_reg)) == 32'h0)
    else $error("Status write set a bit.");
  AST_IRQ_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (irq_stat_reg & irq_en_reg) == 32'h0 |-> !irq_o)
    else $error("Interrupt high with no enabled status bit.");
  AST_ROOT_KEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !selfid_rise |=> $stable(root_reg))
    else $error("Root bit changed outside self-ID end.");
  AST_ONE_SHOT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    tmr_zero && !tmr_rpt_reg && !wr_tmr |=> tmr_cnt_reg == 16'h0 ##1 !tmr_zero)
    else $error("One-shot timer did not stop.");
  // A running offset must step by exactly one per tick, or the cycle length drifts.
  AST_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    tmr_run && tick && !wr_cyc && !(src_ext && ext_rise) &&
    cyc_tm_reg[CYC_OFS_W-1:0] != CYC_OFS_MAX |=>
    cyc_tm_reg[CYC_OFS_W-1:0] == $past(cyc_tm_reg[CYC_OFS_W-1:0]) + 12'h1)
    else $error("Running offset did not advance by one.");

  COV_EXT: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) src_ext && ext_rise);
  COV_WRAP: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) cyc_inc && !src_ext);
  COV_RPT: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) tmr_zero && tmr_rpt_reg);
  COV_RACE: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) (ev & w1c) != 32'h0);
  COV_GAP: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) gap_hit);
endmodule

// file: include/cyt_pkg.sv
// Package with the register map, field layout and timing constants of the cycle timer block.
package cyt_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0c;
  localparam logic [7:0] CYC_TM_OFS = 8'h10;
  localparam logic [7:0] TIMER_OFS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTL_MASTER_BIT = 11;
  localparam int CTL_SOURCE_BIT = 10;
  localparam int CTL_RUN_BIT = 9;
  localparam int CTL_TXIDLE_BIT = 6;
  localparam int CTL_ROOT_BIT = 5;
  localparam int CTL_RETRY_BIT = 4;
  localparam int CTL_ACK_LSB = 27;
  localparam int ACK_W = 4;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0e00;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int IRQ_TIMER_BIT = 20;
  localparam int IRQ_COMMAND_RESET_FLAG_BIT = 18;
  localparam int IRQ_GAP_BIT = 17;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
  localparam int CYC_OFS_W = 12;
  localparam logic [11:0] CYC_OFS_MAX = 12'hbff;
  localparam int CYC_CNT_LSB = 12;
  localparam int CYC_CNT_W = 13;
  localparam logic [31:0] CYC_RESET = 32'h0000_0000;
  localparam int TMR_RPT_BIT = 31;
  localparam int TMR_W = 16;
  localparam logic [3:0] TICK_DIV = 4'h8;
  localparam int CLK_MHZ = 200;
  localparam int FAIR_GAP_NS = 10000;
  localparam int FAIR_GAP_CYC = (FAIR_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_W = 12;
  localparam int SYN_EXT = 0;
  localparam int SYN_TXIDLE = 1;
  localparam int SYN_ROOT = 2;
  localparam int SYN_SELFID = 3;
  localparam int SYN_RETRY = 4;
  localparam int SYN_RSTART = 5;
  localparam int SYN_IDLE = 6;
  localparam int SYN_ACK_LSB = 7;
  localparam int SYN_W = 11;
endpackage

// file: include/cyt_sync_if.sv
// Interface that carries raw pin levels to the synchroniser and clean levels back.
`timescale 1ns/1ps
interface cyt_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// file: hdl/cyt_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
`timescale 1ns/1ps
module cyt_sync
  import cyt_pkg::*;
#(
  parameter int W = SYN_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Pin levels in, clean levels out
  cyt_sync_if.sync sif
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1_reg, s2_reg, s3_reg, clean_reg;
      // A change is accepted only once stages two and three agree.
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          clean_reg <= 1'b0;
        end else begin
          s1_reg <= sif.raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            clean_reg <= s3_reg;
          end
        end
      end
      assign sif.clean[g] = clean_reg;
    end
  endgenerate
endmodule

// file: bench/cyt_host_model.sv
// Host-side AXI4-Lite master model that issues one register access at a time.
`timescale 1ns/1ps
module cyt_host_model
  import cyt_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Write address and data
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  // Write response
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end

  // Both channels are offered together and each is dropped on its own handshake.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk_i);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking testbench for the link cycle timer and interrupt flag registers.
`timescale 1ns/1ps
module testbench;
  import cyt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic external_cycle_input_i = 1'b0, transmitter_idle_flag_i = 1'b0, root_node_i = 1'b0;
  logic selfid_done_i = 1'b0, next_retry_phase_i = 1'b0, reset_start_wr_i = 1'b0;
  logic bus_idle_i = 1'b0;
  logic [ACK_W-1:0] last_async_tx_ack_i = 4'h0;
  logic cycle_start_o, irq_o;
  logic [31:0] rdat;
  logic [1:0] resp;
  int fails = 0;
  int checked = 0;
  int starts = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  cyt_link_regs i_cyt_link_regs (
    .ref_clk_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .external_cycle_input_i, .transmitter_idle_flag_i,
    .root_node_i, .selfid_done_i, .next_retry_phase_i, .last_async_tx_ack_i,
    .reset_start_wr_i, .bus_idle_i, .cycle_start_o, .irq_o
  );

  cyt_host_model i_cyt_host_model (
    .ref_clk_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
  );

  always @(posedge ref_clk_i) begin
    if (cycle_start_o === 1'b1) begin
      starts <= starts + 1;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ww(input logic [7:0] a, input logic [31:0] d);
    i_cyt_host_model.wr(a, d, resp);
  endtask

  task automatic rr(input logic [7:0] a, input logic [31:0] exp);
    i_cyt_host_model.rd(a, rdat, resp);
    chk(rdat, exp);
  endtask

  // Pin pulses stay up six cycles so the synchroniser filter sees a settled level.
  task automatic ext_pulse();
    @(posedge ref_clk_i);
    external_cycle_input_i <= 1'b1;
    cyc(6);
    external_cycle_input_i <= 1'b0;
    cyc(6);
  endtask

  task automatic rst_pulse();
    @(posedge ref_clk_i);
    reset_start_wr_i <= 1'b1;
    cyc(6);
    reset_start_wr_i <= 1'b0;
    cyc(6);
  endtask

  task automatic t_reset();
    rr(CTRL_OFS, CTRL_RESET);
    rr(IRQ_STAT_OFS, IRQ_RESET);
    rr(IRQ_EN_OFS, 32'h0);
    rr(CYC_TM_OFS, CYC_RESET);
    chk(32'(resp), 32'(RESP_OKAY));
    rr(8'h04, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    ww(8'h04, 32'hffff_ffff);
    chk(32'(resp), 32'(RESP_SLVERR));
  endtask

  task automatic t_status();
    logic [31:0] st;
    logic [31:0] rt;
    st = (32'(4'ha) << CTL_ACK_LSB) | (32'h1 << CTL_TXIDLE_BIT) | (32'h1 << CTL_RETRY_BIT);
    rt = 32'h1 << CTL_ROOT_BIT;
    @(posedge ref_clk_i);
    transmitter_idle_flag_i <= 1'b1;
    next_retry_phase_i <= 1'b1;
    last_async_tx_ack_i <= 4'ha;
    root_node_i <= 1'b1;
    cyc(8);
    rr(CTRL_OFS, st);
    selfid_done_i <= 1'b1;
    cyc(8);
    rr(CTRL_OFS, st | rt);
    root_node_i <= 1'b0;
    selfid_done_i <= 1'b0;
    cyc(8);
    rr(CTRL_OFS, st | rt);
    ww(CTRL_OFS, 32'hffff_ffff);
    rr(CTRL_OFS, st | rt | CTRL_WMASK);
    ww(CTRL_OFS, 32'h0);
    transmitter_idle_flag_i <= 1'b0;
    next_retry_phase_i <= 1'b0;
    cyc(8);
    rr(CTRL_OFS, (32'(4'ha) << CTL_ACK_LSB) | rt);
  endtask

  task automatic t_scratch();
    ww(CYC_TM_OFS, 32'ha5a5_5a5a);
    chk(32'(resp), 32'(RESP_OKAY));
    cyc(40);
    rr(CYC_TM_OFS, 32'ha5a5_5a5a);
  endtask

  // The tick phase is free running, so only bounds on the offset are checked.
  task automatic t_wrap();
    logic [31:0] held;
    ww(CYC_TM_OFS, 32'h0000_5bff);
    ww(CTRL_OFS, 32'h1 << CTL_RUN_BIT);
    cyc(12);
    i_cyt_host_model.rd(CYC_TM_OFS, rdat, resp);
    chk(32'(rdat[24:12]), 32'h6);
    chk(32'(rdat[11:0] < 12'h4), 32'h1);
    ww(CTRL_OFS, 32'h0);
    i_cyt_host_model.rd(CYC_TM_OFS, held, resp);
    cyc(40);
    rr(CYC_TM_OFS, held);
  endtask

  task automatic t_external();
    int s0;
    ww(CYC_TM_OFS, 32'h0000_3123);
    ext_pulse();
    rr(CYC_TM_OFS, 32'h0000_3123);
    s0 = starts;
    ww(CTRL_OFS, (32'h1 << CTL_SOURCE_BIT) | (32'h1 << CTL_MASTER_BIT));
    ext_pulse();
    rr(CYC_TM_OFS, 32'h0000_4000);
    chk(32'(starts - s0), 32'h1);
    ww(CTRL_OFS, 32'h1 << CTL_SOURCE_BIT);
    ext_pulse();
    rr(CYC_TM_OFS, 32'h0000_5000);
    chk(32'(starts - s0), 32'h1);
    ww(CTRL_OFS, 32'h0);
  endtask

  task automatic t_irq();
    logic [31:0] cm;
    cm = 32'h1 << IRQ_COMMAND_RESET_FLAG_BIT;
    ww(IRQ_EN_OFS, 32'hffff_ffff);
    rr(IRQ_EN_OFS, 32'hffff_ffff);
    chk(32'(irq_o), 32'h0);
    rst_pulse();
    chk(32'(irq_o), 32'h1);
    rr(IRQ_STAT_OFS, cm);
    ww(IRQ_STAT_OFS, 32'h1 << IRQ_GAP_BIT);
    rr(IRQ_STAT_OFS, cm);
    ww(IRQ_STAT_OFS, cm);
    rr(IRQ_STAT_OFS, 32'h0);
    chk(32'(irq_o), 32'h0);
    ww(IRQ_EN_OFS, ~cm);
    rst_pulse();
    chk(32'(irq_o), 32'h0);
    rr(IRQ_STAT_OFS, cm);
    ww(IRQ_EN_OFS, cm);
    cyc(2);
    chk(32'(irq_o), 32'h1);
    // The write is timed so its clear lands in the very cycle of the new request.
    @(posedge ref_clk_i);
    reset_start_wr_i <= 1'b1;
    cyc(2);
    ww(IRQ_STAT_OFS, cm);
    reset_start_wr_i <= 1'b0;
    cyc(6);
    rr(IRQ_STAT_OFS, cm);
    ww(IRQ_STAT_OFS, cm);
    rr(IRQ_STAT_OFS, 32'h0);
  endtask

  task automatic t_timer();
    logic [31:0] tm;
    tm = 32'h1 << IRQ_TIMER_BIT;
    ww(IRQ_EN_OFS, tm);
    ww(TIMER_OFS, 32'h2);
    cyc(40);
    rr(IRQ_STAT_OFS, tm);
    chk(32'(irq_o), 32'h1);
    rr(TIMER_OFS, 32'h0);
    ww(IRQ_STAT_OFS, tm);
    cyc(40);
    rr(IRQ_STAT_OFS, 32'h0);
    ww(TIMER_OFS, (32'h1 << TMR_RPT_BIT) | 32'h2);
    cyc(40);
    rr(IRQ_STAT_OFS, tm);
    ww(IRQ_STAT_OFS, tm);
    cyc(40);
    rr(IRQ_STAT_OFS, tm);
    ww(TIMER_OFS, 32'h0);
    ww(IRQ_STAT_OFS, tm);
    rr(IRQ_STAT_OFS, 32'h0);
  endtask

  task automatic t_gap();
    logic [31:0] gp;
    gp = 32'h1 << IRQ_GAP_BIT;
    @(posedge ref_clk_i);
    bus_idle_i <= 1'b1;
    cyc(FAIR_GAP_CYC - 100);
    rr(IRQ_STAT_OFS, 32'h0);
    cyc(200);
    rr(IRQ_STAT_OFS, gp);
    ww(IRQ_STAT_OFS, gp);
    cyc(100);
    rr(IRQ_STAT_OFS, 32'h0);
    bus_idle_i <= 1'b0;
  endtask

  task automatic wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(20);
    nrst_i <= 1'b1;
    t_reset();
    t_status();
    t_scratch();
    t_wrap();
    t_external();
    t_irq();
    t_timer();
    t_gap();
    wrap_up();
  end

  // The full sequence needs about three thousand cycles; the margin covers a stuck handshake.
  initial begin
    cyc(20000);
    fails++;
    wrap_up();
  end
endmodule
